// ### shared/analog_fb_pkg.sv
// Package: map, fields, timing and types of the analog feedback control
package analog_fb_pkg;
    // ****************************************************
    // Register map (byte addresses, word index in bits 3:2)
    // ****************************************************
    localparam logic [1:0] IDX_SELECT = 2'h0; // Source and strobe mode
    localparam logic [1:0] IDX_CHOP = 2'h1;   // Offset chop enables
    localparam logic [1:0] IDX_STATUS = 2'h2; // Live state, read only
    // Field positions in the select register
    localparam int SRC_LSB = 0;  // feedback_source_select, 3 bits
    localparam int MODE_B0 = 4;  // strobe_mode_bit0
    localparam int MODE_B1 = 5;  // strobe_mode_bit1
    // Field positions in the status register
    localparam int ST_STROBE = 0;   // Strobe level, 1 = released
    localparam int ST_POL = 1;      // Offset polarity
    localparam int ST_FBEN = 2;     // Feedback enabled
    localparam int ST_BLANK = 3;    // Blanking running
    localparam int ST_LOCK = 4;     // Fault lock on selected output
    localparam int ST_WAIT = 5;     // Waiting after a source change
    // Reset values
    localparam logic [2:0] SRC_RESET = 3'h0;
    localparam logic [1:0] MODE_RESET = 2'h0;
    // Source codes: 0..3 are output channels
    localparam logic [2:0] SRC_VBAT = 3'h4;  // Battery voltage
    localparam logic [2:0] SRC_TEMP = 3'h5;  // Die temperature
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int DEFAULT_PERIOD_US = 6500;  // Clock fail strobe
    localparam int OVF_PULSE_US = 100;        // High pulse at overflow
    localparam int BLANK_US = 60;             // Turn-on plus settling
    localparam int VOLT_DIV = 1024;           // Lowest prescaler
    localparam int DEFAULT_HALF_CYC =
        (DEFAULT_PERIOD_US / 2) * (CLK_HZ / 1_000_000) +
        (DEFAULT_PERIOD_US % 2) * (CLK_HZ / 2_000_000);
    localparam int OVF_PULSE_CYC = OVF_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int BLANK_CYC = BLANK_US * (CLK_HZ / 1_000_000);
    localparam int VOLT_HALF_TICKS = VOLT_DIV / 2;
    // ****************************************************
    // Types
    // ****************************************************
    typedef enum logic [1:0] {
        STROBE_OFF, STROBE_VALID, STROBE_NEXT_CYCLE, STROBE_HALF
    } strobe_mode_e;
    typedef struct packed {
        logic [2:0] source;  // feedback_source_select
        strobe_mode_e mode;  // strobe_mode_bit1:strobe_mode_bit0
    } select_s;
endpackage

// ### logic/analog_fb_ctrl.sv
// Analog feedback routing, offset chopping and sampling strobe control
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
// Notes on behaviour
// - Feedback only in Normal mode
// - Source select field routes the multiplexer
// - No current feedback during inrush window
// - PWM current feedback only in on phase
// - Chop flips offset at each strobe rise
// - Per channel chop enable, reset and fail zero
// - Chop halves full scale and steady threshold
// - Strobe only in Normal, depends on source
// - Mode 00 high, 01 low while valid
// - Mode 10 waits for next PWM cycle
// - Mode 11 low from mid pulse to end
// - No current pulses in inrush or off phase
// - Blank after source change or chop flip
// - Clock fail gives 6.5 ms square wave
// - Full duty in modes 10 and 11: low, 100 us high at overflow
// - After fault, no pulses until re-enabled or source change
// - Voltage source gives clock/1024 square wave
module analog_fb_ctrl #(
    parameter int CHANNELS = 4,                    // Output channels
    parameter int DEFAULT_HALF = analog_fb_pkg::DEFAULT_HALF_CYC,
    parameter int BLANK = analog_fb_pkg::BLANK_CYC // Blanking cycles
) (
    input wire logic ref_clk,                       // 25 MHz clock
    input wire logic rstn,                          // Sync reset, low
    input wire logic [1:0] avs_address,             // Word address
    input wire logic avs_read,                      // Read request
    input wire logic avs_write,                     // Write request
    input wire logic [31:0] avs_writedata,          // Write data
    output logic [31:0] avs_readdata,               // Read data
    output logic avs_waitrequest,                   // Stall the master
    input wire logic normal_mode,                   // Device in Normal
    input wire logic fail_mode,                     // Device in Fail
    input wire logic [CHANNELS-1:0] inrush_overcurrent_window, // OC hi
    input wire logic [CHANNELS-1:0] steady_overcurrent_level,  // OC lo
    input wire logic [CHANNELS-1:0] output_on,      // PWM on phase
    input wire logic [CHANNELS-1:0] full_duty,      // 100% programmed
    input wire logic [CHANNELS-1:0] output_fault,   // Output faulted
    input wire logic [CHANNELS-1:0] output_enable,  // Output enabled
    input wire logic pwm_overflow,                  // Counter overflow
    input wire logic pwm_clk_tick,                  // PWM clock pulse
    input wire logic pwm_clk_fail,                  // PWM clock lost
    output logic [2:0] feedback_source_select,      // Mux route
    output logic analog_feedback_pin_en,            // Feedback on
    output logic offset_chop_mode,                  // Chop active
    output logic offset_polarity,                   // Amp offset sign
    output logic [CHANNELS-1:0] feedback_full_scale_half, // FEEDBACK_FULL_SCALE / 2
    output logic [CHANNELS-1:0] steady_threshold_half,    // STEADY_OVERCURRENT_LEVEL / 2
    output logic sample_strobe_pin_out,             // Pin value, 0
    output logic sample_strobe_pin_oe               // Pull-down on
);
    // ****************************************************
    // Register bus slave
    // ****************************************************
    analog_fb_pkg::select_s sel;              // Source and strobe mode
    logic [CHANNELS-1:0] offset_chop_enable;  // Chop enables
    logic bus_ack;                            // Second cycle of access
    logic [31:0] status_word;                 // Live state view
    logic strobe_n, blank_on, fault_lock, wait_flag, fb_en;
    // One wait state per access: answer at the second edge
    assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
    // Acknowledge toggles so back-to-back requests each wait once
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read | avs_write) & ~bus_ack;
        end
    end
    // Writable registers; fail mode forces chop off
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sel.source <= analog_fb_pkg::SRC_RESET;
            sel.mode <= analog_fb_pkg::strobe_mode_e'(
                analog_fb_pkg::MODE_RESET);
            offset_chop_enable <= '0;
        end else begin
            if (avs_write && bus_ack &&
                avs_address == analog_fb_pkg::IDX_SELECT) begin
                sel.source <= avs_writedata[analog_fb_pkg::SRC_LSB +: 3];
                sel.mode <= analog_fb_pkg::strobe_mode_e'(
                    {avs_writedata[analog_fb_pkg::MODE_B1],
                     avs_writedata[analog_fb_pkg::MODE_B0]});
            end
            if (fail_mode) begin
                offset_chop_enable <= '0;
            end else if (avs_write && bus_ack &&
                avs_address == analog_fb_pkg::IDX_CHOP) begin
                offset_chop_enable <= avs_writedata[CHANNELS-1:0];
            end
        end
    end
    // Status word assembled from live state
    always_comb begin
        status_word = '0;
        status_word[analog_fb_pkg::ST_STROBE] = strobe_n;
        status_word[analog_fb_pkg::ST_POL] = offset_polarity;
        status_word[analog_fb_pkg::ST_FBEN] = fb_en;
        status_word[analog_fb_pkg::ST_BLANK] = blank_on;
        status_word[analog_fb_pkg::ST_LOCK] = fault_lock;
        status_word[analog_fb_pkg::ST_WAIT] = wait_flag;
    end
    // Read data registered; unmapped words read as zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            avs_readdata <= '0;
        end else if (avs_read && !bus_ack) begin
            case (avs_address)
                analog_fb_pkg::IDX_SELECT: begin
                    avs_readdata <= 32'({sel.mode, 1'b0, sel.source});
                end
                analog_fb_pkg::IDX_CHOP: begin
                    avs_readdata <= 32'(offset_chop_enable);
                end
                analog_fb_pkg::IDX_STATUS: begin
                    avs_readdata <= status_word;
                end
                default: begin
                    avs_readdata <= '0;
                end
            endcase
        end
    end
    // ****************************************************
    // Source decode and feedback enable
    // ****************************************************
    logic is_current;            // A channel current is selected
    logic [1:0] ch;              // Selected channel
    logic ch_inrush, ch_on, ch_full, ch_fault, ch_en, ch_steady;
    assign is_current = sel.source < 3'(CHANNELS);
    assign ch = sel.source[1:0];
    assign ch_inrush = is_current & inrush_overcurrent_window[ch];
    assign ch_steady = is_current & steady_overcurrent_level[ch];
    assign ch_on = is_current & output_on[ch];
    assign ch_full = is_current & full_duty[ch];
    assign ch_fault = is_current & output_fault[ch];
    assign ch_en = is_current & output_enable[ch];
    // Current only past inrush and in on phase; voltage always
    assign fb_en = normal_mode & (is_current ?
        (ch_steady & ~ch_inrush & ch_on) : 1'b1);
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            feedback_source_select <= analog_fb_pkg::SRC_RESET;
            analog_feedback_pin_en <= 1'b0;
        end else begin
            feedback_source_select <= sel.source;
            analog_feedback_pin_en <= fb_en;
        end
    end
    // Per channel halving of range and threshold
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_half
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    feedback_full_scale_half[g] <= 1'b0;
                    steady_threshold_half[g] <= 1'b0;
                end else begin
                    feedback_full_scale_half[g] <= offset_chop_enable[g];
                    steady_threshold_half[g] <= offset_chop_enable[g];
                end
            end
        end
    endgenerate
    assign offset_chop_mode = is_current & offset_chop_enable[ch];
    // ****************************************************
    // Events: source change, strobe rise, enable rise
    // ****************************************************
    logic [2:0] last_src;    // Source seen last cycle
    logic strobe_q, en_q;    // Previous strobe level and enable
    logic src_change, strobe_rise, chop_flip;
    assign src_change = sel.source != last_src;
    assign strobe_rise = strobe_n & ~strobe_q;
    assign chop_flip = offset_chop_mode & strobe_rise;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            last_src <= analog_fb_pkg::SRC_RESET;
            strobe_q <= 1'b1;
            en_q <= 1'b0;
        end else begin
            last_src <= sel.source;
            strobe_q <= strobe_n;
            en_q <= ch_en;
        end
    end
    // Offset sign flips at each strobe rise while chopping
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            offset_polarity <= 1'b0;
        end else if (chop_flip) begin
            offset_polarity <= ~offset_polarity;
        end
    end
    // Fixed blanking after a source change or chop flip
    logic [$clog2(BLANK+1)-1:0] blank_cnt;
    assign blank_on = blank_cnt != '0;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            blank_cnt <= '0;
        end else if (src_change || chop_flip) begin
            blank_cnt <= ($clog2(BLANK+1))'(BLANK);
        end else if (blank_on) begin
            blank_cnt <= blank_cnt - 1'b1;
        end
    end
    // Fault lock: set wins over the clear by a new enable
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fault_lock <= 1'b0;
        end else if (ch_fault) begin
            fault_lock <= 1'b1;
        end else if ((ch_en && !en_q) || src_change) begin
            fault_lock <= 1'b0;
        end
    end
    // ****************************************************
    // Mid-pulse tracking for the half-pulse mode
    // ****************************************************
    logic [15:0] on_len, half_len; // Running and previous half length
    logic on_q;                    // On phase last cycle
    logic past_mid;                // Past the middle of this pulse
    assign past_mid = ch_on & (on_len >= half_len);
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            on_len <= '0;
            half_len <= '0;
            on_q <= 1'b0;
        end else begin
            on_q <= ch_on;
            if (ch_on) begin
                on_len <= on_len + 1'b1;
            end else begin
                on_len <= '0;
            end
            // Pulse length taken from the previous pulse, a limitation
            if (on_q && !ch_on) begin
                half_len <= {1'b0, on_len[15:1]};
            end
        end
    end
    // Wait flag: after a source change until next cycle or midpoint
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wait_flag <= 1'b0;
        end else if (src_change) begin
            wait_flag <= 1'b1;
        end else if (sel.mode == analog_fb_pkg::STROBE_HALF) begin
            if (past_mid && !blank_on) begin
                wait_flag <= 1'b0;
            end
        end else if (pwm_overflow) begin
            wait_flag <= 1'b0;
        end
    end
    // ****************************************************
    // Square waves and overflow pulse
    // ****************************************************
    logic [$clog2(DEFAULT_HALF+1)-1:0] def_cnt;  // Clock fail half
    logic def_wave;                              // 6.5 ms square
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            def_cnt <= '0;
            def_wave <= 1'b1;
        end else if (def_cnt == ($clog2(DEFAULT_HALF+1))'(DEFAULT_HALF-1)) begin
            def_cnt <= '0;
            def_wave <= ~def_wave;
        end else begin
            def_cnt <= def_cnt + 1'b1;
        end
    end
    logic [9:0] volt_cnt;  // PWM clock ticks in half period
    logic volt_wave;       // Clock/1024 square
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            volt_cnt <= '0;
            volt_wave <= 1'b1;
        end else if (pwm_clk_tick) begin
            if (volt_cnt == 10'(analog_fb_pkg::VOLT_HALF_TICKS - 1)) begin
                volt_cnt <= '0;
                volt_wave <= ~volt_wave;
            end else begin
                volt_cnt <= volt_cnt + 1'b1;
            end
        end
    end
    localparam int OVF_W = $clog2(analog_fb_pkg::OVF_PULSE_CYC + 1);
    logic [OVF_W-1:0] ovf_cnt;  // High pulse at overflow
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ovf_cnt <= '0;
        end else if (pwm_overflow) begin
            ovf_cnt <= OVF_W'(analog_fb_pkg::OVF_PULSE_CYC);
        end else if (ovf_cnt != '0) begin
            ovf_cnt <= ovf_cnt - 1'b1;
        end
    end
    // ****************************************************
    // Strobe selection
    // ****************************************************
    logic valid;  // Current feedback valid for sampling
    assign valid = fb_en & ~blank_on & ~fault_lock;
    logic next_strobe_n;
    always_comb begin
        next_strobe_n = 1'b1;
        if (!normal_mode) begin
            next_strobe_n = 1'b1;
        end else if (pwm_clk_fail) begin
            next_strobe_n = def_wave;
        end else if (!is_current) begin
            next_strobe_n = volt_wave;
        end else begin
            case (sel.mode)
                analog_fb_pkg::STROBE_OFF: begin
                    next_strobe_n = 1'b1;
                end
                analog_fb_pkg::STROBE_VALID: begin
                    next_strobe_n = ~valid;
                end
                analog_fb_pkg::STROBE_NEXT_CYCLE: begin
                    if (ch_full && !fault_lock && !ch_inrush) begin
                        next_strobe_n = ovf_cnt != '0;
                    end else begin
                        next_strobe_n = ~(valid & ~wait_flag);
                    end
                end
                analog_fb_pkg::STROBE_HALF: begin
                    if (ch_full && !fault_lock && !ch_inrush) begin
                        next_strobe_n = ovf_cnt != '0;
                    end else begin
                        next_strobe_n = ~(valid & past_mid & ~wait_flag);
                    end
                end
                default: begin
                    next_strobe_n = 1'b1;
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            strobe_n <= 1'b1;
        end else begin
            strobe_n <= next_strobe_n;
        end
    end
    // Open drain: pull down while low, else released to pull-up
    assign sample_strobe_pin_out = 1'b0;
    assign sample_strobe_pin_oe = ~strobe_n;
    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_sleep_released: assert property (!normal_mode |=> strobe_n)
        else $error("strobe low outside normal mode");
    a_fb_off_inrush: assert property (ch_inrush |=> !analog_feedback_pin_en)
        else $error("feedback during inrush window");
    a_fb_on_only: assert property (!ch_on && is_current |=> !analog_feedback_pin_en)
        else $error("feedback in off phase");
    a_pol_flip: assert property (chop_flip |=> offset_polarity != $past(offset_polarity))
        else $error("chop polarity did not flip");
    a_fail_chop: assert property (fail_mode |=> offset_chop_enable == '0)
        else $error("chop enabled in fail mode");
    a_mode_off: assert property (normal_mode && !pwm_clk_fail && is_current && sel.mode == analog_fb_pkg::STROBE_OFF |=> strobe_n)
        else $error("strobe low in off mode");
    a_blank_run: assert property (src_change |=> blank_on [*8])
        else $error("blanking too short");
    a_lock_quiet: assert property (fault_lock && normal_mode && !pwm_clk_fail && is_current && !ch_full |=> strobe_n)
        else $error("strobe pulse during fault lock");
    a_halve_track: assert property (##1 feedback_full_scale_half == $past(offset_chop_enable))
        else $error("range halving not following enable");
    a_pin_map: assert property (sample_strobe_pin_oe == !strobe_n)
        else $error("pin enable mismatch");
    c_valid_strobe: cover property (sel.mode == analog_fb_pkg::STROBE_VALID && !strobe_n);
    c_half_strobe: cover property (sel.mode == analog_fb_pkg::STROBE_HALF && !strobe_n);
    c_chop_flip: cover property (chop_flip);
    c_clk_fail: cover property (pwm_clk_fail && normal_mode ##1 strobe_rise);
endmodule

// ### verification/host_sampler.sv
// Host model: watches the sampling strobe wire and times its edges
`timescale 1ns/1ns
module host_sampler (
    input wire logic ref_clk,   // System clock
    input wire logic strobe_oe, // Pull-down enable from the device
    output int edges,           // Wire edges seen
    output int gap              // Cycles between the last two edges
);
    // ****************************************************
    // Wire level and edge timing
    // ****************************************************
    logic level;     // Wire with external pull-up
    logic prev = 1;  // Level sampled at the last clock
    int run = 0;     // Cycles since the last edge
    int n = 0;       // Edge count
    int g = 0;       // Last gap
    // Released wire floats up to the pull-up level
    assign level = strobe_oe ? 1'b0 : 1'b1;
    assign edges = n;
    assign gap = g;
    // Sample once per clock, as the ADC trigger logic would
    always @(posedge ref_clk) begin
        prev <= level;
        if (prev !== level) begin
            n <= n + 1;
            g <= run;
            run <= 1;
        end else begin
            run <= run + 1;
        end
    end
endmodule

// ### verification/tb_analog_fb_ctrl.sv
// Self-checking bench of the analog feedback control block
`timescale 1ns/1ns
module tb_analog_fb_ctrl;
    // ****************************************************
    // Stimulus, model and checks
    // ****************************************************
    logic ref_clk = 0, rstn = 0, rd = 0, wr = 0;  // Clock, reset, bus
    logic [1:0] adr = 2'h0;                       // Word address
    logic [31:0] wd = 32'h0, q;                   // Bus data
    logic nm = 1, fm = 0, ovf = 0, tick = 1, cf = 0; // Mode, PWM inputs
    logic [3:0] ir = 4'h0, st = 4'h0, on_ph = 4'h0, fd = 4'h0; // Channel
    logic [3:0] flt = 4'h0, en = 4'hF, chop;      // Channel
    wire [31:0] rdata;                            // Read data
    wire [2:0] src;                               // Mux route
    wire [3:0] fsh, thh;                          // Halved ranges
    wire wait_n, fb_en, chm, pol, sout, soe;      // Outputs
    int num_errors = 0, checks_done = 0, cyc = 0, seed = 44152, e0;
    int regm [4] = '{0, 0, 0, 0};                 // Register model
    int edges, gap;                               // From the host model
    logic [1:0] ch;                               // Channel under test
    logic p0;                                     // Polarity before flip
    analog_fb_ctrl #(.DEFAULT_HALF(50), .BLANK(10)) analog_fb_ctrl_inst (
        .ref_clk(ref_clk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
        .avs_waitrequest(wait_n), .normal_mode(nm), .fail_mode(fm),
        .inrush_overcurrent_window(ir), .steady_overcurrent_level(st),
        .output_on(on_ph), .full_duty(fd), .output_fault(flt),
        .output_enable(en), .pwm_overflow(ovf), .pwm_clk_tick(tick),
        .pwm_clk_fail(cf), .feedback_source_select(src),
        .analog_feedback_pin_en(fb_en), .offset_chop_mode(chm),
        .offset_polarity(pol), .feedback_full_scale_half(fsh),
        .steady_threshold_half(thh), .sample_strobe_pin_out(sout),
        .sample_strobe_pin_oe(soe));
    host_sampler host_sampler_inst (.ref_clk(ref_clk), .strobe_oe(soe),
        .edges(edges), .gap(gap));
    // Free-running 25 MHz clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // Verdict and end of run
    task automatic close_out();
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Compare one result with the expected value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus cycle; the request holds until waitrequest is seen low
    task automatic bus(input logic w, input logic [1:0] a,
                       input logic [31:0] d);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge ref_clk); while (wait_n !== 1'b0);
        q = rdata;
        rd <= 0;
        wr <= 0;
        if (!w) chk(q, regm[a]);
        if (w && a == 2'h0) regm[0] = d & 32'h37;
        if (w && a == 2'h1) regm[1] = d & 32'hF;
        @(posedge ref_clk);
    endtask
    // Let a number of cycles pass
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Wait for further edges of the strobe wire
    task automatic wait_edges(input int n);
        e0 = edges;
        while (edges < e0 + n) @(posedge ref_clk);
    endtask
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            close_out();
        end
    end
    // Main sequence
    initial begin
        idle(4);
        rstn <= 1;
        @(posedge ref_clk);
        chk({sout, soe}, 2'h0);
        bus(1, 2'h3, 32'hFF);
        bus(1, 2'h2, 32'hFF);
        bus(0, 2'h0, 0);
        bus(0, 2'h1, 0);
        bus(0, 2'h3, 0);
        ch = $random(seed) & 3;
        chop = ($random(seed) & 4'hF) | (4'h1 << ch);
        bus(1, 2'h0, {26'h0, 2'h1, 1'b0, 1'b0, ch});
        bus(1, 2'h1, {28'h0, chop});
        bus(0, 2'h0, 0);
        bus(0, 2'h1, 0);
        chk({src, fsh, thh, chm}, {1'b0, ch, chop, chop, 1'b1});
        on_ph[ch] <= 1;
        st[ch] <= 1;
        idle(20);
        chk({fb_en, soe}, 2'h3);
        p0 = pol;
        ir[ch] <= 1;
        idle(4);
        chk({fb_en, soe, pol}, {2'h0, ~p0});
        ir[ch] <= 0;
        on_ph[ch] <= 0;
        idle(20);
        chk({fb_en, soe}, 2'h0);
        on_ph[ch] <= 1;
        nm <= 0;
        idle(20);
        chk({fb_en, soe}, 2'h0);
        nm <= 1;
        bus(1, 2'h0, {30'h0, ch});
        idle(20);
        chk(soe, 1'b0);
        bus(1, 2'h0, {26'h0, 2'h1, 2'h0, ch});
        idle(20);
        flt[ch] <= 1;
        idle(3);
        flt[ch] <= 0;
        idle(20);
        chk(soe, 1'b0);
        // A fresh enable of the output lifts the lock again
        en[ch] <= 0;
        @(posedge ref_clk);
        en[ch] <= 1;
        idle(5);
        chk(soe, 1'b1);
        fd[ch] <= 1;
        bus(1, 2'h0, {26'h0, 2'h2, 2'h0, ch});
        idle(5);
        chk(soe, 1'b1);
        ovf <= 1;
        @(posedge ref_clk);
        ovf <= 0;
        idle(20);
        chk(soe, 1'b0);
        ovf <= 1;
        @(posedge ref_clk);
        ovf <= 0;
        idle(2400);
        chk(soe, 1'b0);
        idle(200);
        chk(soe, 1'b1);
        // Half-pulse mode: one 40 cycle pulse sets the length to halve
        fd[ch] <= 0;
        bus(1, 2'h0, {26'h0, 2'h3, 2'h0, ch});
        on_ph[ch] <= 0;
        idle(10);
        on_ph[ch] <= 1;
        idle(40);
        on_ph[ch] <= 0;
        idle(10);
        on_ph[ch] <= 1;
        idle(10);
        chk(soe, 1'b0);
        idle(25);
        chk(soe, 1'b1);
        bus(1, 2'h0, {26'h0, 2'h1, 1'b0, analog_fb_pkg::SRC_VBAT});
        wait_edges(3);
        chk(gap, 512);
        cf <= 1;
        wait_edges(3);
        chk(gap, 50);
        // Fail mode clears the chop enables and refuses new ones
        fm <= 1;
        bus(1, 2'h1, 32'hF);
        regm[1] = 0;
        bus(0, 2'h1, 0);
        chk({fsh, thh}, 8'h0);
        close_out();
    end
endmodule
